// >>> core/interval_timer_params.svh
// Constants of the four channel interval timer
`ifndef INTERVAL_TIMER_PARAMS_SVH
`define INTERVAL_TIMER_PARAMS_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define COUNT_W 24
`define CH_NUM 4
`define CH_SEL_W 2

// ****************************************************************
// Reset values
// ****************************************************************
`define COUNT_RST 24'hff_ffff
`define INTERVAL_RST 24'h00_0000
`define FLAG_RST 4'h0

`endif

// >>> core/interval_timer_pkg.sv
// Types shared by the interval timer files
`include "interval_timer_params.svh"

package interval_timer_pkg;

	// Channel operating modes; the fourth code is illegal
	typedef enum logic [1:0] {
		MODE_REPEAT,
		MODE_ONE_SHOT,
		MODE_STALL
	} mode_t;

	// Channel phase
	typedef enum logic {
		PH_IDLE,
		PH_RUN
	} phase_t;

	// One interval write from the processor side
	typedef struct packed {
		logic valid;
		logic [`CH_SEL_W-1:0] channel;
		logic [`COUNT_W-1:0] value;
		logic force_load;
	} wr_req_t;

	// State of one channel
	typedef struct packed {
		phase_t phase;
		logic [`COUNT_W-1:0] count;
		logic [`COUNT_W-1:0] interval;
	} chan_state_t;

endpackage

// >>> core/timer_channel.sv
// One down-counting timer channel
`timescale 1ns/100ps
`default_nettype none
`include "interval_timer_params.svh"

module timer_channel
	import interval_timer_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// Configuration
	input wire interval_timer_pkg::mode_t mode_i,
	// Interval write
	input wire logic load_i,
	input wire logic [`COUNT_W-1:0] value_i,
	input wire logic force_load_i,
	// Status
	output logic [`COUNT_W-1:0] count_o,
	output logic running_o,
	output logic event_o
);

	chan_state_t st_ff;
	chan_state_t nxt_st;
	logic [`COUNT_W-1:0] next_iv;

	// ****************************************************************
	// Next state
	// ****************************************************************
	// Forced writes win over a zero in the same cycle, so they never
	// raise an event of their own.
	always_comb
	begin
		nxt_st = st_ff;
		event_o = 1'b0;
		next_iv = load_i ? value_i : st_ff.interval;
		unique case (st_ff.phase)
			PH_IDLE:
			begin
				nxt_st.interval = next_iv;
				if (load_i && value_i != '0)
				begin
					nxt_st.count = value_i - `COUNT_W'(1);
					nxt_st.phase = PH_RUN;
				end
			end
			PH_RUN:
			begin
				nxt_st.interval = next_iv;
				if (load_i && force_load_i)
				begin
					if (value_i != '0)
						nxt_st.count = value_i - `COUNT_W'(1);
					else
						nxt_st.phase = PH_IDLE;
				end
				else if (st_ff.count == '0)
				begin
					event_o = 1'b1;
					if (mode_i == MODE_REPEAT && next_iv != '0)
						nxt_st.count = next_iv - `COUNT_W'(1);
					else
						nxt_st.phase = PH_IDLE;
				end
				else
					nxt_st.count = st_ff.count - `COUNT_W'(1);
			end
		endcase
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			st_ff.phase <= PH_IDLE;
			st_ff.count <= `COUNT_RST;
			st_ff.interval <= `INTERVAL_RST;
		end
		else
			st_ff <= nxt_st;
	end

	assign count_o = st_ff.count;
	assign running_o = (st_ff.phase == PH_RUN);

endmodule

`default_nettype wire

// >>> core/multi_rate_timer.sv
// Four channel interval timer with stalling write and shared interrupt
`timescale 1ns/100ps
`default_nettype none
`include "interval_timer_params.svh"

module multi_rate_timer
	import interval_timer_pkg::*;
#(
	parameter int CHANNELS = `CH_NUM
)
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_i,

	// Interval write port
	input wire interval_timer_pkg::wr_req_t wr_i,
	output logic wr_ready_o,

	// Per channel configuration
	input wire interval_timer_pkg::mode_t [CHANNELS-1:0] mode_i,
	input wire logic [CHANNELS-1:0] irq_enable_i,

	// Pending flag clear, one bit per channel
	input wire logic [CHANNELS-1:0] irq_clear_i,

	// Channel status
	output logic [CHANNELS-1:0][`COUNT_W-1:0] count_o,
	output logic [CHANNELS-1:0] running_o,
	output logic [CHANNELS-1:0] irq_flag_o,

	// First idle channel
	output logic idle_found_o,
	output logic [`CH_SEL_W-1:0] idle_channel_o,

	// Global interrupt
	output logic irq_o
);

	// ****************************************************************
	// Local types
	// ****************************************************************
	// All module state in one word
	typedef struct packed {
		logic [CHANNELS-1:0] flag;
		logic stall_busy;
		logic [`CH_SEL_W-1:0] stall_ch;
		logic idle_found;
		logic [`CH_SEL_W-1:0] idle_ch;
	} top_state_t;

	top_state_t st_ff;
	top_state_t nxt_st;

	// ****************************************************************
	// Channel wiring
	// ****************************************************************
	logic [CHANNELS-1:0] load;
	logic [CHANNELS-1:0] chan_event;
	logic [CHANNELS-1:0] chan_running;
	logic [CHANNELS-1:0][`COUNT_W-1:0] chan_count;

	// Write decode
	logic target_is_stall;
	logic stall_start;
	logic stall_done;

	// ****************************************************************
	// Write port decode
	// ****************************************************************
	// A stall-mode write with a nonzero interval starts its channel on
	// the first cycle it is presented, then ready stays low until that
	// channel reaches zero. The requester must hold the same request
	// the whole time; the port serves one write at a time, so every
	// other write waits behind a stalled one as on a shared bus.
	always_comb
	begin
		target_is_stall = (mode_i[wr_i.channel] == MODE_STALL);
		stall_start = wr_i.valid && !st_ff.stall_busy
			&& target_is_stall && (wr_i.value != '0);
		stall_done = st_ff.stall_busy
			&& chan_event[st_ff.stall_ch];
		if (st_ff.stall_busy)
			wr_ready_o = stall_done;
		else
			wr_ready_o = !stall_start;
	end

	// Channel load strobes: a write lands only while no stall is open
	always_comb
	begin
		for (int i = 0; i < CHANNELS; i++)
		begin
			load[i] = wr_i.valid && !st_ff.stall_busy
				&& (wr_i.channel == `CH_SEL_W'(i));
		end
	end

	// ****************************************************************
	// Channels
	// ****************************************************************
	// Identical, independent counters; nothing is shared between them
	// except the write port.
	for (genvar g = 0; g < CHANNELS; g++)
	begin : gen_chan
		timer_channel u_chan
		(
			.clock_i(clock_i),
			.reset_i(reset_i),
			.mode_i(mode_i[g]),
			.load_i(load[g]),
			.value_i(wr_i.value),
			.force_load_i(wr_i.force_load),
			.count_o(chan_count[g]),
			.running_o(chan_running[g]),
			.event_o(chan_event[g])
		);
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	// Pending flags are sticky. A new event in the cycle of its clear
	// wins, so no event is ever lost. Stall-mode channels signal their
	// end through the write port and do not flag an interrupt.
	always_comb
	begin
		nxt_st = st_ff;
		for (int i = 0; i < CHANNELS; i++)
		begin
			nxt_st.flag[i] = (st_ff.flag[i] && !irq_clear_i[i])
				|| (chan_event[i]
				&& mode_i[i] != MODE_STALL);
		end

		// Stall tracking
		if (stall_start)
		begin
			nxt_st.stall_busy = 1'b1;
			nxt_st.stall_ch = wr_i.channel;
		end
		else if (stall_done)
			nxt_st.stall_busy = 1'b0;

		// Lowest numbered idle channel, for software that picks a free one
		nxt_st.idle_found = 1'b0;
		nxt_st.idle_ch = '0;
		for (int i = CHANNELS - 1; i >= 0; i--)
		begin
			if (!chan_running[i])
			begin
				nxt_st.idle_found = 1'b1;
				nxt_st.idle_ch = `CH_SEL_W'(i);
			end
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			st_ff.flag <= `FLAG_RST;
			st_ff.stall_busy <= 1'b0;
			st_ff.stall_ch <= '0;
			st_ff.idle_found <= 1'b0;
			st_ff.idle_ch <= '0;
		end
		else
			st_ff <= nxt_st;
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Counters and flags straight from their registers
	assign count_o = chan_count;
	assign running_o = chan_running;
	assign irq_flag_o = st_ff.flag;
	assign idle_found_o = st_ff.idle_found;
	assign idle_channel_o = st_ff.idle_ch;

	// One request line for all channels; no pins beyond these ports
	assign irq_o = |(st_ff.flag & irq_enable_i);

endmodule

`default_nettype wire

// >>> test/multi_rate_timer_assertions.sv
// Port checker for the interval timer
`timescale 1ns/100ps
`default_nettype none
`include "interval_timer_params.svh"
module timer_checker
	import interval_timer_pkg::*;
#(
	parameter int CHANNELS = 4
)
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// Watched ports
	input wire interval_timer_pkg::wr_req_t wr_i,
	input wire logic wr_ready_o,
	input wire interval_timer_pkg::mode_t [CHANNELS-1:0] mode_i,
	input wire logic [CHANNELS-1:0] irq_enable_i,
	input wire logic [CHANNELS-1:0][`COUNT_W-1:0] count_o,
	input wire logic [CHANNELS-1:0] running_o,
	input wire logic [CHANNELS-1:0] irq_flag_o,
	input wire logic irq_o
);
	// ******
	// Accepted writes to channels 0 and 1
	// ******
	logic wr0;
	logic wr1;
	logic [`CH_SEL_W-1:0] c;
	assign wr0 = wr_i.valid && wr_ready_o && wr_i.channel == 2'h0;
	assign wr1 = wr_i.valid && wr_ready_o && wr_i.channel == 2'h1;
	assign c = wr_i.channel;
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (reset_i);
	AST_IRQ_OR: assert property (
		irq_o == |(irq_flag_o & irq_enable_i))
		else $error("global interrupt wrong");
	AST_LOAD_IDLE: assert property (
		wr0 && !running_o[0] && wr_i.value != 0
		|=> running_o[0] && count_o[0] == $past(wr_i.value) - 24'h1)
		else $error("idle load wrong");
	AST_COUNT_DOWN: assert property (
		running_o[0] && count_o[0] != 0 && !wr0
		|=> count_o[0] == $past(count_o[0]) - 24'h1)
		else $error("count did not step down");
	AST_EVENT_FLAG: assert property (
		running_o[0] && count_o[0] == 0 && !wr0
		&& mode_i[0] != MODE_STALL |=> irq_flag_o[0])
		else $error("event flag missing");
	AST_ONESHOT_STOP: assert property (
		mode_i[1] == MODE_ONE_SHOT
		&& running_o[1] && count_o[1] == 0 && !wr1
		|=> !running_o[1] && irq_flag_o[1])
		else $error("one-shot did not stop");
	AST_FORCE_STOP: assert property (
		wr1 && wr_i.force_load && wr_i.value == 0
		|=> !running_o[1] && $stable(count_o[1]))
		else $error("forced stop wrong");
	AST_STALL_HOLD: assert property (
		wr_i.valid && mode_i[c] == MODE_STALL
		&& running_o[c] && count_o[c] != 0 |-> !wr_ready_o)
		else $error("stall write completed early");
	AST_STALL_DONE: assert property (
		wr_i.valid && mode_i[c] == MODE_STALL
		&& running_o[c] && count_o[c] == 0 |-> wr_ready_o)
		else $error("stall write not completed");
endmodule
bind multi_rate_timer timer_checker #(.CHANNELS(CHANNELS)) chk (
	.clock_i, .reset_i, .wr_i, .wr_ready_o, .mode_i, .irq_enable_i,
	.count_o, .running_o, .irq_flag_o, .irq_o
);
`default_nettype wire

// >>> test/cpu_writer.sv
// Processor side model that issues interval writes
`timescale 1ns/100ps
`default_nettype none
module cpu_writer
	import interval_timer_pkg::*;
(
	// Clock
	input wire logic clock_i,
	// Write port
	output interval_timer_pkg::wr_req_t wr_o,
	input wire logic wr_ready_i
);
	// ******
	// Released bus shows inverted fields, never the last request
	// ******
	initial wr_o = {1'b0, {($bits(wr_req_t) - 1){1'b1}}};
	// Hold the request until ready is seen high or 400 edges pass; count edges waited
	task automatic write(input wr_req_t r, output int waited);
		@(negedge clock_i);
		wr_o <= r;
		waited = 0;
		do
		begin
			@(posedge clock_i);
			waited++;
		end
		while (!wr_ready_i && waited < 400);
		@(negedge clock_i);
		wr_o <= {1'b0, ~r[$bits(wr_req_t)-2:0]};
	endtask
endmodule
`default_nettype wire

// >>> test/test_multi_rate_timer.sv
// Self-checking bench for the interval timer
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
	$display("MISMATCH %0t got %h want %h", $time, (g), (e)); end end
module test_multi_rate_timer;
	import interval_timer_pkg::*;
	// One step: write, wait, expected channel state
	typedef struct {
		logic [1:0] ch;
		logic [23:0] v;
		logic f;
		int w;
		logic [23:0] cnt;
		logic cc;
		logic run;
		logic flg;
	} row_t;
	row_t rows[11] = '{
		'{2'h0, 24'h5, 1'h0, 2, 24'h2, 1'h1, 1'h1, 1'h0},
		'{2'h0, 24'h9, 1'h0, 1, 24'h8, 1'h1, 1'h1, 1'h1},
		'{2'h0, 24'h3, 1'h1, 0, 24'h2, 1'h1, 1'h1, 1'h0},
		'{2'h0, 24'h0, 1'h0, 1, 24'h0, 1'h0, 1'h0, 1'h1},
		'{2'h1, 24'h4, 1'h0, 1, 24'h2, 1'h1, 1'h1, 1'h0},
		'{2'h1, 24'h6, 1'h1, 2, 24'h3, 1'h1, 1'h1, 1'h0},
		'{2'h1, 24'h0, 1'h1, 3, 24'h2, 1'h1, 1'h0, 1'h0},
		'{2'h1, 24'h2, 1'h0, 2, 24'h0, 1'h0, 1'h0, 1'h1},
		'{2'h2, 24'h1, 1'h0, 3, 24'h0, 1'h1, 1'h1, 1'h1},
		'{2'h2, 24'h0, 1'h1, 2, 24'h0, 1'h1, 1'h0, 1'h0},
		'{2'h2, 24'hff_ffff, 1'h0, 3, 24'hff_fffb, 1'h1, 1'h1, 1'h0}
	};
	logic clock_i = 1'b0;
	logic reset_i = 1'b1;
	wr_req_t wr;
	logic wr_ready_o;
	mode_t [3:0] mode_i =
		'{MODE_STALL, MODE_REPEAT, MODE_ONE_SHOT, MODE_REPEAT};
	logic [3:0] irq_enable_i = 4'hf;
	logic [3:0] irq_clear_i = 4'h0;
	logic [3:0][23:0] count_o;
	logic [3:0] running_o;
	logic [3:0] irq_flag_o;
	logic irq_o;
	logic idle_found_o;
	logic [1:0] idle_channel_o;
	int errors = 0;
	int checks = 0;
	int n;
	always #50 clock_i = ~clock_i;
	multi_rate_timer dut (
		.clock_i, .reset_i, .wr_i(wr), .wr_ready_o, .mode_i, .irq_enable_i,
		.irq_clear_i, .count_o, .running_o, .irq_flag_o, .idle_found_o,
		.idle_channel_o, .irq_o
	);
	cpu_writer cpu (.clock_i, .wr_o(wr), .wr_ready_i(wr_ready_o));
	// ******
	// Verdict and end of run
	// ******
	task automatic test_done;
		if (errors == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Watchdog: tests need about 64 cycles, allow about thirty times that
	initial
	begin
		#200_000;
		errors++;
		test_done;
	end
	// Rows first, flags cleared around each write so only new events show
	initial
	begin
		repeat (8) @(negedge clock_i);
		reset_i <= 1'b0;
		foreach (rows[i])
		begin
			irq_clear_i <= 4'hf;
			cpu.write('{1'b1, rows[i].ch, rows[i].v, rows[i].f}, n);
			irq_clear_i <= 4'h0;
			repeat (rows[i].w) @(negedge clock_i);
			// Writes to non-stall channels complete on their first edge
			`CHK(n, 1)
			if (rows[i].cc)
				`CHK(count_o[rows[i].ch], rows[i].cnt)
			`CHK(running_o[rows[i].ch], rows[i].run)
			`CHK(irq_flag_o[rows[i].ch], rows[i].flg)
			// Channel 0 runs here, so channel 1 is the lowest idle one
			if (i == 1)
				`CHK({idle_found_o, idle_channel_o}, 3'h5)
		end
		// Second reset while channel 2 counts
		reset_i <= 1'b1;
		repeat (2) @(negedge clock_i);
		`CHK(count_o, {4{24'hff_ffff}})
		`CHK({running_o, irq_flag_o, irq_o}, 9'h0)
		`CHK({idle_found_o, idle_channel_o}, 3'h0)
		reset_i <= 1'b0;
		// Masked event, then enabled, then cleared
		irq_enable_i <= 4'h0;
		cpu.write('{1'b1, 2'h1, 24'h1, 1'h0}, n);
		@(negedge clock_i);
		`CHK(irq_flag_o, 4'h2)
		`CHK(irq_o, 1'b0)
		irq_enable_i <= 4'h2;
		@(negedge clock_i);
		`CHK(irq_o, 1'b1)
		irq_clear_i <= 4'h2;
		@(negedge clock_i);
		irq_clear_i <= 4'h0;
		`CHK(irq_o, 1'b0)
		// Stalled write of five counts completes on the sixth edge
		cpu.write('{1'b1, 2'h3, 24'h5, 1'h0}, n);
		`CHK(n, 6)
		`CHK({running_o[3], irq_flag_o[3]}, 2'h0)
		`CHK({idle_found_o, idle_channel_o}, 3'h4)
		test_done;
	end
endmodule
`default_nettype wire
